// ==== hdl/aql_defs.vh ====
`ifndef AQL_DEFS_VH
`define AQL_DEFS_VH

// Register word offsets
`define AQL_OFS_CTRL      4'h0
`define AQL_OFS_STATUS    4'h1
`define AQL_OFS_IRQ_STAT  4'h2
`define AQL_OFS_IRQ_MASK  4'h3

// Control register fields
`define AQL_CTRL_EDM_CFG  0
`define AQL_CTRL_CODING   1
`define AQL_CTRL_LINKED   2
`define AQL_CTRL_FORCE    3
`define AQL_CTRL_RESET    32'h0000_0000

// Interrupt status fields
`define AQL_IRQ_SHOW      0
`define AQL_IRQ_BLANK     1
`define AQL_IRQ_SYNCLOST  2
`define AQL_IRQ_FAULT     3
`define AQL_IRQ_W         4

// Quality levels
`define AQL_LVL_NONE      3'h0
`define AQL_LVL_ONE       3'h1
`define AQL_LVL_TWO       3'h2
`define AQL_LVL_THREE     3'h3
`define AQL_LVL_FOUR      3'h4

// Timing: 200 MHz clock, 5 ns period
`define AQL_CLK_NS        5
`define AQL_ALIGN_MS      3000
// Divide first so the products stay inside 32-bit integer range
`define AQL_ALIGN_CYC     (`AQL_ALIGN_MS * (1000000 / `AQL_CLK_NS))
`define AQL_BLANK_MS      5000
`define AQL_BLANK_CYC     (`AQL_BLANK_MS * (1000000 / `AQL_CLK_NS))
`define AQL_FLASH_MS      250
`define AQL_FLASH_CYC     (`AQL_FLASH_MS * (1000000 / `AQL_CLK_NS))

// Lamp colour codes
`define AQL_LAMP_OFF      2'h0
`define AQL_LAMP_RED      2'h1
`define AQL_LAMP_GREEN    2'h2
`define AQL_LAMP_YELLOW   2'h3

`endif

// ==== hdl/aql_timer.v ====
`timescale 1ns/1ps
`default_nettype none
// Counts while run is high; done stays high from the count until run falls
module aql_timer
#(
  parameter integer COUNT = 16,
  parameter integer W     = 32
)
(
  // Clock and reset
  input  wire         ref_clk_in,
  input  wire         resetn_in,
  // Control
  input  wire         run_in,
  output reg          done_out
);

  reg  [W-1:0] cnt_reg;

  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_reg  <= {W{1'b0}};
      done_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_reg  <= {W{1'b0}};
      done_out <= 1'b0;
    end
    else if (cnt_reg >= COUNT[W-1:0] - {{(W-1){1'b0}}, 1'b1})
    begin
      done_out <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // aql_timer
`default_nettype wire

// ==== hdl/aql_flasher.v ====
`timescale 1ns/1ps
`default_nettype none
// Free-running square wave for flashing overlays
module aql_flasher
#(
  parameter integer HALF = 16,
  parameter integer W    = 32
)
(
  // Clock and reset
  input  wire         ref_clk_in,
  input  wire         resetn_in,
  // Phase
  output reg          phase_out
);

  reg  [W-1:0] cnt_reg;

  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_reg   <= {W{1'b0}};
      phase_out <= 1'b0;
    end
    else if (cnt_reg >= HALF[W-1:0] - {{(W-1){1'b0}}, 1'b1})
    begin
      cnt_reg   <= {W{1'b0}};
      phase_out <= ~phase_out;
    end
    else
    begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // aql_flasher
`default_nettype wire

// ==== hdl/aql_encoder.v ====
// Operation
// - Show quality again on rising contamination, laser aid on, or alignment over 3 s.
// - Blank the quality display a fixed delay after alignment with a clear field.
// - With no beam synchronized all eight diagnostic LEDs stay off.
// - Level one lights only LED 1 blue among LEDs 1 to 4.
// - Level two lights LEDs 1 and 2 blue, 3 and 4 off.
// - Level three lights LEDs 1 to 3 blue, LED 4 off.
// - Level four lights LEDs 1 to 4 blue.
// - LEDs 5 and 6 are blue while the topmost beam is synchronized.
// - LEDs 7 and 8 are blue while the bottommost beam is synchronized.
// - A monitoring warning with monitoring configured flashes LED 1 only.
// - A reset pushbutton fault flashes LED 4 only.
// - Wide fields may cap the level so LED 4 lights only to flash a reset pushbutton fault.
// - A cabled sender lamp copies the receiver output-state lamp.
// - An unconnected, fault-free running sender shows a yellow lamp.
// - In normal operation LED 3 is white when beam coding 1 or 2 is set, a beam is synchronized and the quality display is blanked.
`timescale 1ns/1ps
`default_nettype none
`include "aql_defs.vh"
module aql_encoder
#(
  parameter integer ALIGN_CYC = `AQL_ALIGN_CYC,
  parameter integer BLANK_CYC = `AQL_BLANK_CYC,
  parameter integer FLASH_CYC = `AQL_FLASH_CYC
)
(
  // Clock and reset
  input  wire         ref_clk_in,
  input  wire         resetn_in,
  // Avalon-MM slave
  input  wire [3:0]   avs_address_in,
  input  wire         avs_read_in,
  input  wire         avs_write_in,
  input  wire [31:0]  avs_writedata_in,
  input  wire [3:0]   avs_byteenable_in,
  output reg  [31:0]  avs_readdata_out,
  output reg          avs_waitrequest_out,
  output reg          irq_out,
  // Beam evaluator
  input  wire         any_sync_in,
  input  wire         top_sync_in,
  input  wire         bottom_sync_in,
  input  wire [2:0]   quality_in,
  input  wire         wide_field_in,
  input  wire         field_clear_in,
  input  wire         aligned_in,
  input  wire         contamination_up_in,
  input  wire         laser_aid_in,
  input  wire         normal_op_in,
  // Fault sources
  input  wire         monitoring_warn_in,
  input  wire         reset_button_fault_in,
  input  wire         sender_fault_in,
  input  wire         sender_running_in,
  input  wire [1:0]   safety_switch_output_lamp_in,
  // Diagnostic LEDs
  output reg  [7:0]   led_blue_out,
  output reg  [7:0]   led_white_out,
  output reg  [1:0]   sender_status_lamp_out
);

  localparam [2:0] ST_SHOW  = 3'b001;
  localparam [2:0] ST_WAIT  = 3'b010;
  localparam [2:0] ST_BLANK = 3'b100;

  // Level to thermometer code; used for display and status readback
  function [3:0] thermo;
    input [2:0] lvl;
    begin
      case (lvl)
        `AQL_LVL_NONE:  thermo = 4'h0;
        `AQL_LVL_ONE:   thermo = 4'h1;
        `AQL_LVL_TWO:   thermo = 4'h3;
        `AQL_LVL_THREE: thermo = 4'h7;
        default:        thermo = 4'hf;
      endcase
    end
  endfunction

  reg  [31:0]            ctrl_reg;
  reg  [`AQL_IRQ_W-1:0]  irq_stat_reg;
  reg  [`AQL_IRQ_W-1:0]  irq_mask_reg;
  reg  [2:0]             state_reg;
  reg  [2:0]             state_next;
  reg                    contam_d_reg;
  reg                    laser_d_reg;
  reg                    sync_d_reg;
  reg                    fault_d_reg;
  reg                    ack_reg;
  reg  [2:0]             level;
  reg  [3:0]             q_leds;
  reg  [7:0]             blue_next;
  reg  [7:0]             white_next;
  reg  [1:0]             lamp_next;
  reg  [31:0]            rdata;
  reg  [`AQL_IRQ_W-1:0]  ev;
  wire                   align_long;
  wire                   blank_done;
  wire                   flash;
  wire                   show_req;
  wire                   fault_now;
  wire                   access;

  assign access    = (avs_read_in | avs_write_in) & ~ack_reg;
  assign fault_now = monitoring_warn_in | reset_button_fault_in;
  assign show_req  = (contamination_up_in & ~contam_d_reg) |
                     (laser_aid_in & ~laser_d_reg) | align_long |
                     ctrl_reg[`AQL_CTRL_FORCE];

  // Alignment in progress too long
  aql_timer
  #(
    .COUNT (ALIGN_CYC),
    .W     (32)
  )
  u_align_timer
  (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .run_in     (any_sync_in & ~aligned_in & (state_reg == ST_BLANK)),
    .done_out   (align_long)
  );

  // Blanking delay after alignment with a clear field
  aql_timer
  #(
    .COUNT (BLANK_CYC),
    .W     (32)
  )
  u_blank_timer
  (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .run_in     (state_reg == ST_WAIT),
    .done_out   (blank_done)
  );

  aql_flasher
  #(
    .HALF (FLASH_CYC),
    .W    (32)
  )
  u_flasher
  (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .phase_out  (flash)
  );

  // Display state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_SHOW:
      begin
        if (aligned_in & field_clear_in & ~show_req)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (show_req | ~aligned_in | ~field_clear_in)
          state_next = ST_SHOW;
        else if (blank_done)
          state_next = ST_BLANK;
      end
      ST_BLANK:
      begin
        if (show_req)
          state_next = ST_SHOW;
      end
      default:
        state_next = ST_SHOW;
    endcase
  end

  // LED pattern
  always @*
  begin
    level = quality_in;
    if (level > `AQL_LVL_FOUR)
      level = `AQL_LVL_FOUR;
    if (wide_field_in & (level == `AQL_LVL_FOUR))
      level = `AQL_LVL_THREE;
    if (level == `AQL_LVL_NONE)
      level = `AQL_LVL_ONE;
    q_leds = thermo(level);
    if (ctrl_reg[`AQL_CTRL_EDM_CFG] & monitoring_warn_in)
      q_leds[0] = flash;
    if (reset_button_fault_in)
      q_leds[3] = flash;
    blue_next  = 8'h00;
    white_next = 8'h00;
    if (!any_sync_in)
    begin
      blue_next = 8'h00;
    end
    else
    begin
      if (state_reg != ST_BLANK)
        blue_next[3:0] = q_leds;
      blue_next[5:4] = {2{top_sync_in}};
      blue_next[7:6] = {2{bottom_sync_in}};
    end
    // White coding mark only while quality display is dark
    if (any_sync_in & normal_op_in & (state_reg == ST_BLANK) &
        ctrl_reg[`AQL_CTRL_CODING])
      white_next[2] = 1'b1;
    if (ctrl_reg[`AQL_CTRL_LINKED])
      lamp_next = safety_switch_output_lamp_in;
    else if (sender_running_in & ~sender_fault_in)
      lamp_next = `AQL_LAMP_YELLOW;
    else
      lamp_next = `AQL_LAMP_OFF;
  end

  // Events for interrupt status
  always @*
  begin
    ev = {`AQL_IRQ_W{1'b0}};
    ev[`AQL_IRQ_SHOW]     = (state_reg == ST_BLANK) & (state_next == ST_SHOW);
    ev[`AQL_IRQ_BLANK]    = (state_reg == ST_WAIT) & (state_next == ST_BLANK);
    ev[`AQL_IRQ_SYNCLOST] = sync_d_reg & ~any_sync_in;
    ev[`AQL_IRQ_FAULT]    = fault_now & ~fault_d_reg;
  end

  // Read mux
  always @*
  begin
    rdata = 32'h0000_0000;
    case (avs_address_in)
      `AQL_OFS_CTRL:     rdata = ctrl_reg;
      `AQL_OFS_STATUS:   rdata = {19'h0_0000, state_reg, level,
                                  any_sync_in, top_sync_in, bottom_sync_in,
                                  thermo(level)};
      `AQL_OFS_IRQ_STAT: rdata = {28'h000_0000, irq_stat_reg};
      `AQL_OFS_IRQ_MASK: rdata = {28'h000_0000, irq_mask_reg};
      default:           rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg              <= ST_SHOW;
      ctrl_reg               <= `AQL_CTRL_RESET;
      irq_stat_reg           <= {`AQL_IRQ_W{1'b0}};
      irq_mask_reg           <= {`AQL_IRQ_W{1'b0}};
      contam_d_reg           <= 1'b0;
      laser_d_reg            <= 1'b0;
      sync_d_reg             <= 1'b0;
      fault_d_reg            <= 1'b0;
      ack_reg                <= 1'b0;
      avs_readdata_out       <= 32'h0000_0000;
      avs_waitrequest_out    <= 1'b1;
      irq_out                <= 1'b0;
      led_blue_out           <= 8'h00;
      led_white_out          <= 8'h00;
      sender_status_lamp_out <= `AQL_LAMP_OFF;
    end
    else
    begin
      state_reg              <= state_next;
      contam_d_reg           <= contamination_up_in;
      laser_d_reg            <= laser_aid_in;
      sync_d_reg             <= any_sync_in;
      fault_d_reg            <= fault_now;
      led_blue_out           <= blue_next;
      led_white_out          <= white_next;
      sender_status_lamp_out <= lamp_next;
      irq_out                <= |(irq_stat_reg & irq_mask_reg);
      // One wait cycle, then a one-cycle acknowledge
      ack_reg                <= access;
      avs_waitrequest_out    <= ~access;
      if (access & avs_read_in)
        avs_readdata_out <= rdata;
      // Writes land on the acknowledge edge; set wins over a clear
      if (ack_reg & avs_write_in & (avs_address_in == `AQL_OFS_IRQ_STAT) &
          avs_byteenable_in[0])
        irq_stat_reg <= (irq_stat_reg & ~avs_writedata_in[3:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      if (ack_reg & avs_write_in & avs_byteenable_in[0])
      begin
        if (avs_address_in == `AQL_OFS_CTRL)
          ctrl_reg <= {28'h000_0000, avs_writedata_in[3:0]};
        if (avs_address_in == `AQL_OFS_IRQ_MASK)
          irq_mask_reg <= avs_writedata_in[3:0];
      end
    end
  end

endmodule // aql_encoder
`default_nettype wire

// ==== tb/aql_encoder_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module aql_encoder_checker (
  // Clock, reset and handshake
  input wire logic       ref_clk_in,
  input wire logic       resetn_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  // Beam and fault inputs
  input wire logic       any_sync_in,
  input wire logic       top_sync_in,
  input wire logic       bottom_sync_in,
  input wire logic       wide_field_in,
  input wire logic       normal_op_in,
  input wire logic       reset_button_fault_in,
  // Diagnostic LEDs
  input wire logic [7:0] led_blue_out,
  input wire logic [7:0] led_white_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence req_taken;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence ack_cycle;
    !avs_waitrequest_out;
  endsequence
  ack_follows_a: assert property (req_taken |=> ack_cycle)
    else $error("request without acknowledge");
  ack_single_a: assert property (ack_cycle |=> avs_waitrequest_out)
    else $error("acknowledge held too long");
  ack_cause_a: assert property ($fell(avs_waitrequest_out) |->
    $past(avs_read_in || avs_write_in))
    else $error("acknowledge without request");
  dark_nosync_a: assert property (!any_sync_in |=>
    led_blue_out == 8'h00) else $error("LEDs lit without sync");
  top_off_a: assert property (!top_sync_in |=>
    led_blue_out[5:4] == 2'b00) else $error("top pair lit");
  bottom_off_a: assert property (!bottom_sync_in |=>
    led_blue_out[7:6] == 2'b00) else $error("bottom pair lit");
  thermo_order_a: assert property (led_blue_out[2] |->
    led_blue_out[1]) else $error("quality LEDs not thermometer");
  wide_cap_a: assert property (wide_field_in &&
    !reset_button_fault_in |=> !led_blue_out[3])
    else $error("LED 4 lit on wide field");
  white_cause_a: assert property (led_white_out[2] |->
    $past(any_sync_in && normal_op_in)) else $error("white LED 3 uncaused");
endmodule // aql_encoder_checker
bind aql_encoder aql_encoder_checker u_chk (.ref_clk_in, .resetn_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .any_sync_in,
  .top_sync_in, .bottom_sync_in, .wide_field_in, .normal_op_in,
  .reset_button_fault_in, .led_blue_out, .led_white_out);
`default_nettype wire

// ==== tb/aql_beam_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aql_beam_model (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  // Scene from the bench
  input  wire logic [2:0] level_in,
  input  wire logic       top_in,
  input  wire logic       bottom_in,
  // Evaluator results
  output var  logic       any_sync_out,
  output var  logic       top_sync_out,
  output var  logic       bottom_sync_out,
  output var  logic [2:0] quality_out
);
  // Level zero without edge beams means no beam at all
  always_ff @(posedge ref_clk_in or negedge resetn_in)
    if (!resetn_in)
      {any_sync_out, top_sync_out, bottom_sync_out, quality_out} <= 6'h00;
    else
      {any_sync_out, top_sync_out, bottom_sync_out, quality_out} <=
        {(level_in != 3'h0) | top_in | bottom_in, top_in, bottom_in, level_in};
endmodule // aql_beam_model
`default_nettype wire

// ==== tb/tb_alignment_quality_led_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aql_defs.vh"
module tb_alignment_quality_led_encoder;
  logic        ref_clk_in, resetn_in, avs_read_in, avs_write_in, irq_out;
  logic        avs_waitrequest_out, any_sync_in, top_sync_in, bottom_sync_in;
  logic        wide_field_in, field_clear_in, aligned_in, laser_aid_in;
  logic        contamination_up_in, normal_op_in, monitoring_warn_in;
  logic        reset_button_fault_in, sender_fault_in, sender_running_in;
  logic        s_top, s_bot;
  logic [2:0]  quality_in, s_lvl;
  logic [3:0]  avs_address_in;
  logic [1:0]  safety_switch_output_lamp_in, sender_status_lamp_out;
  logic [7:0]  led_blue_out, led_white_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n;
  aql_beam_model u_beam (.ref_clk_in, .resetn_in, .level_in(s_lvl),
    .top_in(s_top), .bottom_in(s_bot), .any_sync_out(any_sync_in),
    .top_sync_out(top_sync_in), .bottom_sync_out(bottom_sync_in),
    .quality_out(quality_in));
  aql_encoder #(.ALIGN_CYC(20), .BLANK_CYC(30), .FLASH_CYC(4)) DUT (
    .ref_clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_readdata_out,
    .avs_waitrequest_out, .irq_out, .any_sync_in, .top_sync_in,
    .bottom_sync_in, .quality_in, .wide_field_in, .field_clear_in,
    .aligned_in, .contamination_up_in, .laser_aid_in, .normal_op_in,
    .monitoring_warn_in, .reset_button_fault_in, .sender_fault_in,
    .sender_running_in, .safety_switch_output_lamp_in, .led_blue_out,
    .led_white_out, .sender_status_lamp_out);
  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic look;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  // Request held until waitrequest is seen low at a falling edge, then dropped at the next rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_in);
    {avs_address_in, avs_writedata_in} <= {a, d};
    {avs_write_in, avs_read_in} <= {wr, !wr};
    @(negedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0 && k < 20)
    begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k == 20)
      chk(32'h0000_0000, 32'hFFFF_FFFF);
    if (k == 20)
      stop_test;
    @(posedge ref_clk_in);
    q = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'h0;
  endtask
  task automatic scene(input logic [2:0] l, input logic t, input logic b);
    @(posedge ref_clk_in);
    {s_lvl, s_top, s_bot} <= {l, t, b};
    look;
  endtask
  // Bounded wait on the quality nibble
  task automatic wait_led(input logic [3:0] v);
    n = 0;
    while (led_blue_out[3:0] !== v && n < 100)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n == 100)
      chk(32'h0000_0000, 32'hFFFF_FFFF);
    if (n == 100)
      stop_test;
  endtask
  task automatic t_regs;
    bus(1'b0, `AQL_OFS_CTRL, 32'h0000_0000);
    chk(q, `AQL_CTRL_RESET);
    bus(1'b1, 4'h7, 32'hFFFF_FFFF);
    bus(1'b0, 4'h7, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_levels;
    for (int i = 0; i < 5; i++)
    begin
      scene(i[2:0], 1'b1, 1'b1);
      chk(32'(led_blue_out), (i == 0) ? 32'hF1 : 32'hF0 | ((1 << i) - 1));
    end
    scene(3'h0, 1'b1, 1'b0);
    chk(32'(led_blue_out), 32'h0000_0031);
    scene(3'h3, 1'b0, 1'b1);
    chk(32'(led_blue_out), 32'h0000_00C7);
    bus(1'b0, `AQL_OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_05D7);
    @(posedge ref_clk_in);
    wide_field_in <= 1'b1;
    scene(3'h4, 1'b1, 1'b1);
    chk(32'(led_blue_out), 32'h0000_00F7);
    @(posedge ref_clk_in);
    wide_field_in <= 1'b0;
    scene(3'h0, 1'b0, 1'b0);
    chk(32'(led_blue_out), 32'h0000_0000);
  endtask
  task automatic t_flash;
    logic [7:0] a;
    @(posedge ref_clk_in);
    reset_button_fault_in <= 1'b1;
    scene(3'h2, 1'b1, 1'b1);
    a = led_blue_out;
    repeat (4) @(negedge ref_clk_in);
    chk({a[3] ^ led_blue_out[3], a[2:0]}, 32'h0000_000B);
    // Sync loss from the last level scene, then the fault rise
    bus(1'b0, `AQL_OFS_IRQ_STAT, 32'h0000_0000);
    chk(q, 32'h0000_000C);
    @(posedge ref_clk_in);
    reset_button_fault_in <= 1'b0;
    monitoring_warn_in <= 1'b1;
    bus(1'b1, `AQL_OFS_CTRL, 32'h0000_0001);
    scene(3'h3, 1'b1, 1'b1);
    a = led_blue_out;
    repeat (4) @(negedge ref_clk_in);
    chk({a[3:1], a[0] ^ led_blue_out[0]}, 32'h0000_0007);
  endtask
  task automatic t_blank;
    bus(1'b1, `AQL_OFS_CTRL, 32'h0000_0002);
    bus(1'b1, `AQL_OFS_IRQ_STAT, 32'h0000_000F);
    bus(1'b1, `AQL_OFS_IRQ_MASK, 32'h0000_0002);
    monitoring_warn_in <= 1'b0;
    {aligned_in, field_clear_in, normal_op_in} <= 3'h7;
    scene(3'h4, 1'b1, 1'b1);
    chk(32'(led_blue_out), 32'h0000_00FF);
    wait_led(4'h0);
    look;
    chk({n > 15, irq_out, led_white_out[2]}, 32'h0000_0007);
    bus(1'b0, `AQL_OFS_IRQ_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    bus(1'b1, `AQL_OFS_IRQ_MASK, 32'h0000_0000);
    look;
    chk(32'(irq_out), 32'h0000_0000);
    bus(1'b1, `AQL_OFS_IRQ_MASK, 32'h0000_0002);
    bus(1'b1, `AQL_OFS_IRQ_STAT, 32'h0000_0002);
    look;
    chk(32'(irq_out), 32'h0000_0000);
    for (int k = 0; k < 3; k++)
    begin
      if (k > 0)
        wait_led(4'h0);
      @(posedge ref_clk_in);
      {laser_aid_in, contamination_up_in} <= {k == 0, k == 1};
      aligned_in <= (k != 2);
      wait_led(4'hF);
      chk(32'(k < 2 || n > 15), 32'h0000_0001);
      @(posedge ref_clk_in);
      {laser_aid_in, contamination_up_in, aligned_in} <= 3'h1;
    end
    // Software force brings the blanked display back at once
    wait_led(4'h0);
    bus(1'b1, `AQL_OFS_CTRL, 32'h0000_0008);
    wait_led(4'hF);
    chk(32'(n < 10), 32'h0000_0001);
  endtask
  task automatic t_lamp;
    bus(1'b1, `AQL_OFS_CTRL, 32'h0000_0004);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk_in);
      safety_switch_output_lamp_in <= k[1:0];
      look;
      chk(32'(sender_status_lamp_out), 32'(k));
    end
    bus(1'b1, `AQL_OFS_CTRL, 32'h0000_0000);
    sender_running_in <= 1'b1;
    look;
    chk(32'(sender_status_lamp_out), 32'(`AQL_LAMP_YELLOW));
  endtask
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = !ref_clk_in;
  end
  initial
  begin
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    {wide_field_in, field_clear_in, aligned_in, laser_aid_in} = '0;
    {contamination_up_in, normal_op_in, monitoring_warn_in} = '0;
    {reset_button_fault_in, sender_fault_in, sender_running_in} = '0;
    {safety_switch_output_lamp_in, s_lvl, s_top, s_bot} = '0;
    resetn_in = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_regs;
    t_levels;
    t_flash;
    t_blank;
    t_lamp;
    stop_test;
  end
endmodule // tb_alignment_quality_led_encoder
`default_nettype wire
